// *** pie_cpu_model.sv ***
// CPU side model: takes offered vectors and performs event transfers.
// Assumes the clk_sys domain and the carriers of pie_pkg.
module pie_cpu_model
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // Block outputs
    input wire pie_cpu_type cpuOut,
    input wire pie_xfer_type xferOut,
    // Pace and answer
    input wire logic slow,
    output logic cpuAck
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] vecQ[$];
    logic [40:0] xfQ[$];
    int waitCnt = 0;
    // Acknowledge after a short or long think time; a withdrawn offer restarts it
    always @(posedge clk_sys) begin
        cpuAck <= 1'b0;
        if (!rstn || cpuOut.irqReq !== 1'b1 || cpuAck) begin
            waitCnt <= 0;
        end else if (waitCnt >= (slow ? 3 : 0)) begin
            cpuAck <= 1'b1;
            vecQ.push_back({cpuOut.irqLevel, cpuOut.irqVec});
        end else begin
            waitCnt <= waitCnt + 1;
        end
        // One entry per strobe cycle, so a stretched strobe shows up
        if (rstn && xferOut.stb === 1'b1) begin
            xfQ.push_back({xferOut.word, xferOut.src, xferOut.dst, xferOut.left});
        end
    end
endmodule

// *** pie_irq_ctrl.sv ***
// Prioritised vectored interrupts, event transfer channels and
// fast external interrupt inputs with power-down control.
// Assumes a CPU that acknowledges requests and performs the one-cycle
// transfers it is handed; all inputs are synchronous to clk_sys.
`include "pie_map.svh"

module pie_irq_ctrl
    import pie_pkg::*;
(
    // Clock, reset and enable
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // APB register port
    input wire pie_apb_req_type apbReq,
    output pie_apb_rsp_type apbRsp,
    // Request sources
    input wire logic [7:0] fastPin,
    input wire logic canRx0,
    input wire logic canRx1,
    input wire logic [7:0] perReq,
    // CPU side
    input wire logic [3:0] cpuLevel,
    input wire logic cpuAck,
    input wire logic trapValid,
    input wire logic [3:0] trapNum,
    input wire logic pdActive,
    output pie_cpu_type cpuOut,
    output pie_xfer_type xferOut,
    output logic pdAllow,
    output logic pdWake,
    output logic irqOut
);

    pie_reg_type s_q;
    pie_reg_type s_d;
    logic [7:0] altSrc;
    logic [7:0] fastLvl;
    logic [7:0] fastEvt;
    logic [7:0] pdOk;
    logic [7:0] wakeV;
    logic [15:0] srcEvt;
    logic [15:0] wd;
    logic [15:0] rdv;
    pie_win_type w;
    pie_src_type cur;
    logic [2:0] curChIdx;
    pie_chan_type curCh;
    logic goXfer;
    logic [15:0] step;
    pie_dec_type dec;

    // Winner: strictly above the CPU level, ties go to the lowest index
    function automatic pie_win_type arbPick(
        input pie_src_type [`PIE_NSRC-1:0] sv,
        input logic [3:0] lvl
    );
        pie_win_type r;
        logic [3:0] best;
        r = '0;
        best = lvl;
        for (int i = 0; i < `PIE_NSRC; i++) begin
            if (sv[i].req && sv[i].en && sv[i].prio > best) begin
                best = sv[i].prio;
                r.found = 1'b1;
                r.idx = 4'(i);
            end
        end
        return r;
    endfunction

    // Fast input source mux
    function automatic logic pickLvl(
        input logic [1:0] ss,
        input logic pin,
        input logic alt
    );
        logic r;
        unique case (ss)
            `PIE_SS_PIN: r = pin;
            `PIE_SS_ALT: r = alt;
            `PIE_SS_OR: r = pin | alt;
            `PIE_SS_AND: r = pin & alt;
        endcase
        return r;
    endfunction

    // Register index decode, shared by read and write paths
    function automatic pie_dec_type decode(input logic [15:0] idx);
        pie_dec_type d;
        d.kind = PIE_K_NONE;
        d.sub = idx[3:0];
        if (idx == `PIE_IDX_EDGE_CFG) d.kind = PIE_K_EDGE;
        else if (idx == `PIE_IDX_SRC_SEL) d.kind = PIE_K_SEL;
        else if (idx == `PIE_IDX_IRQ_STAT) d.kind = PIE_K_STAT;
        else if (idx == `PIE_IDX_IRQ_MASK) d.kind = PIE_K_MASK;
        else if ((idx & `PIE_IDX_M16) == `PIE_IDX_SRC_CTL) d.kind = PIE_K_SRC;
        else if ((idx & `PIE_IDX_M8) == `PIE_IDX_CH_CTL) d.kind = PIE_K_CHC;
        else if ((idx & `PIE_IDX_M8) == `PIE_IDX_CH_SRC) d.kind = PIE_K_CHS;
        else if ((idx & `PIE_IDX_M8) == `PIE_IDX_CH_DST) d.kind = PIE_K_CHD;
        return d;
    endfunction

    // Alternate sources: two CAN receive lines, rest tied low
    assign altSrc = {6'h00, canRx1, canRx0};

    // Fast inputs, one slice per input
    for (genvar g = 0; g < `PIE_NFAST; g++) begin : g_fast
        logic [1:0] es;
        logic rise;
        logic fall;
        assign es = s_q.edgeCfg[2*g +: 2];
        assign fastLvl[g] = pickLvl(s_q.srcSel[2*g +: 2], fastPin[g], altSrc[g]);
        assign rise = fastLvl[g] & ~s_q.prevIn[g];
        assign fall = ~fastLvl[g] & s_q.prevIn[g];
        // Edge code picks the request edge
        assign fastEvt[g] = (es == `PIE_ES_RISE && rise)
            || (es == `PIE_ES_FALL && fall)
            || (es == `PIE_ES_ANY && (rise || fall));
        // Disabled inputs always permit sleep and never wake
        assign pdOk[g] = (es == `PIE_ES_RISE) ? ~fastLvl[g]
            : (es == `PIE_ES_FALL) ? fastLvl[g] : 1'b1;
        assign wakeV[g] = (es == `PIE_ES_RISE) ? fastLvl[g]
            : (es == `PIE_ES_FALL) ? ~fastLvl[g]
            : (es == `PIE_ES_ANY) ? (fastLvl[g] ^ s_q.pdLvl[g])
            : 1'b0;
    end

    // Sources 0-7 are the fast inputs, 8-15 peripheral pulses
    assign srcEvt = {perReq, fastEvt};
    assign w = arbPick(s_q.src, cpuLevel);
    assign cur = s_q.src[s_q.win];
    assign curChIdx = cur.ch;
    assign curCh = s_q.ch[curChIdx];
    // Continuous channels never run down, so they always transfer
    assign goXfer = s_q.st == PIE_WAIT && s_q.cnt == 3'h0 && !s_q.isTrap
        && cur.xfer && (curCh.ctl.cont || curCh.ctl.cnt != 8'h00);
    assign step = curCh.ctl.word ? `PIE_STEP_WORD : `PIE_STEP_BYTE;
    assign dec = decode(apbReq.paddr[17:2]);
    assign wd = apbReq.pwdata[15:0];

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;
        rdv = 16'h0000;
        s_d.xo.stb = 1'b0;
        // Read mux
        unique case (dec.kind)
            PIE_K_NONE: rdv = 16'h0000;
            PIE_K_EDGE: rdv = s_q.edgeCfg;
            PIE_K_SEL: rdv = s_q.srcSel;
            PIE_K_SRC: rdv = 16'(s_q.src[dec.sub]);
            PIE_K_CHC: rdv = 16'(s_q.ch[dec.sub[2:0]].ctl);
            PIE_K_CHS: rdv = s_q.ch[dec.sub[2:0]].srcPtr;
            PIE_K_CHD: rdv = s_q.ch[dec.sub[2:0]].dstPtr;
            PIE_K_STAT: rdv = {8'h00, s_q.stat};
            PIE_K_MASK: rdv = {8'h00, s_q.mask};
        endcase
        // One wait state: data is ready the cycle after access starts
        if (apbReq.psel && apbReq.penable && !s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.prdata = {16'h0000, rdv};
            s_d.rsp.pslverr = (dec.kind == PIE_K_NONE);
        end else if (s_q.rsp.pready) begin
            s_d.rsp.pready = 1'b0;
            s_d.rsp.pslverr = 1'b0;
            // Writes land on the completing edge only
            if (apbReq.psel && apbReq.penable && apbReq.pwrite) begin
                unique case (dec.kind)
                    PIE_K_NONE: s_d.rsp.pslverr = 1'b0;
                    PIE_K_EDGE: s_d.edgeCfg = wd;
                    PIE_K_SEL: s_d.srcSel = wd;
                    PIE_K_SRC: s_d.src[dec.sub] = pie_src_type'(wd[`PIE_SRC_W-1:0]);
                    PIE_K_CHC: s_d.ch[dec.sub[2:0]].ctl = pie_chctl_type'(wd[`PIE_CHC_W-1:0]);
                    PIE_K_CHS: s_d.ch[dec.sub[2:0]].srcPtr = wd;
                    PIE_K_CHD: s_d.ch[dec.sub[2:0]].dstPtr = wd;
                    PIE_K_STAT: s_d.stat = s_q.stat & ~wd[7:0];
                    PIE_K_MASK: s_d.mask = wd[7:0];
                endcase
            end
        end
        // Power-down permission and wake, level caught while awake
        s_d.prevIn = fastLvl;
        if (!pdActive) begin
            s_d.pdLvl = fastLvl;
        end
        s_d.pdAllow = &pdOk;
        s_d.pdWake = pdActive && (|wakeV);
        // Service sequencer
        unique case (s_q.st)
            PIE_IDLE: begin
                // Traps are software-driven and go ahead of sources
                if (s_q.trapPend) begin
                    s_d.isTrap = 1'b1;
                    s_d.win = s_q.trapNum;
                    s_d.cnt = 3'(`PIE_WAIT_CYC);
                    s_d.st = PIE_WAIT;
                end else if (w.found) begin
                    s_d.isTrap = 1'b0;
                    s_d.win = w.idx;
                    s_d.cnt = 3'(`PIE_WAIT_CYC);
                    s_d.st = PIE_WAIT;
                end
            end
            PIE_WAIT: begin
                // Padding keeps the response inside its time window
                if (s_q.cnt != 3'h0) begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end else if (goXfer) begin
                    // Single stolen cycle, no vector fetch
                    s_d.xo.stb = 1'b1;
                    s_d.xo.word = curCh.ctl.word;
                    s_d.xo.src = curCh.srcPtr;
                    s_d.xo.dst = curCh.dstPtr;
                    if (curCh.ctl.incDst) begin
                        s_d.ch[curChIdx].dstPtr = curCh.dstPtr + step;
                    end else begin
                        s_d.ch[curChIdx].srcPtr = curCh.srcPtr + step;
                    end
                    if (curCh.ctl.cont) begin
                        s_d.xo.left = curCh.ctl.cnt;
                    end else begin
                        s_d.xo.left = curCh.ctl.cnt - 8'h01;
                        s_d.ch[curChIdx].ctl.cnt = curCh.ctl.cnt - 8'h01;
                        if (curCh.ctl.cnt == 8'h01) begin
                            s_d.stat[curChIdx] = 1'b1;
                        end
                    end
                    s_d.src[s_q.win].req = 1'b0;
                    s_d.st = PIE_IDLE;
                end else if (!s_q.isTrap
                    && !(cur.req && cur.en && cur.prio > cpuLevel)) begin
                    // Withdrawn, or the CPU rose to this level while padding
                    s_d.st = PIE_IDLE;
                end else begin
                    s_d.cpu.irqReq = 1'b1;
                    s_d.cpu.irqLevel = s_q.isTrap ? cpuLevel : cur.prio;
                    s_d.cpu.irqVec = `PIE_VEC_BASE + {10'h000, s_q.win, 2'h0};
                    s_d.st = PIE_REQ;
                end
            end
            PIE_REQ: begin
                if (cpuAck) begin
                    s_d.cpu.irqReq = 1'b0;
                    if (s_q.isTrap) begin
                        s_d.trapPend = 1'b0;
                    end else begin
                        s_d.src[s_q.win].req = 1'b0;
                    end
                    s_d.st = PIE_IDLE;
                end else if (!s_q.isTrap
                    && (cur.prio <= cpuLevel || !cur.en || !cur.req)) begin
                    // CPU rose to this level, or the source was disabled or withdrawn: offer dropped
                    s_d.cpu.irqReq = 1'b0;
                    s_d.st = PIE_IDLE;
                end
            end
        endcase
        // Late sets win over clears made above
        if (trapValid) begin
            s_d.trapPend = 1'b1;
            s_d.trapNum = trapNum;
        end
        for (int i = 0; i < `PIE_NSRC; i++) begin
            if (srcEvt[i]) begin
                s_d.src[i].req = 1'b1;
            end
        end
        s_d.irqOut = |(s_d.stat & s_d.mask);
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.edgeCfg <= `PIE_RST_EDGE_CFG;
            s_q.srcSel <= `PIE_RST_SRC_SEL;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign apbRsp = s_q.rsp;
    assign cpuOut = s_q.cpu;
    assign xferOut = s_q.xo;
    assign pdAllow = s_q.pdAllow;
    assign pdWake = s_q.pdWake;
    assign irqOut = s_q.irqOut;

    // Checks, counted in enabled cycles only
    localparam int LatHold = `PIE_WAIT_CYC;
    localparam int LatMax = `PIE_LAT_MAX_CYC;
    logic [3:0] pastWin;
    assign pastWin = s_q.win;

    default clocking cb @(posedge clk_sys iff ce);
    endclocking
    default disable iff (!rstn);

    property p_lat;
        $rose(s_q.st == PIE_WAIT) |-> ##LatHold (s_q.st == PIE_WAIT && s_q.cnt == 3'h0)
            ##1 (s_q.cpu.irqReq || s_q.xo.stb || s_q.st == PIE_IDLE);
    endproperty
    a_lat: assert property (p_lat) else $error("service latency off");

    property p_lat_max;
        (s_q.st == PIE_IDLE && !s_q.trapPend && w.found)
            |-> ##[1:LatMax] (s_q.cpu.irqReq || s_q.xo.stb || s_q.st == PIE_IDLE);
    endproperty
    a_lat_max: assert property (p_lat_max) else $error("service too late");

    property p_xone;
        s_q.xo.stb |=> !s_q.xo.stb && !s_q.cpu.irqReq;
    endproperty
    a_xone: assert property (p_xone) else $error("transfer not one cycle");

    property p_cnt;
        (goXfer && !curCh.ctl.cont) |=> s_q.xo.stb
            && s_q.xo.left == $past(curCh.ctl.cnt) - 8'h01;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count not decremented");

    property p_tc;
        (s_q.st == PIE_WAIT && s_q.cnt == 3'h0 && !s_q.isTrap && cur.xfer
            && cur.req && cur.en && cur.prio > cpuLevel
            && !curCh.ctl.cont && curCh.ctl.cnt == 8'h00)
            |=> s_q.cpu.irqReq && !s_q.xo.stb;
    endproperty
    a_tc: assert property (p_tc) else $error("terminal count no interrupt");

    property p_vec;
        ($rose(s_q.cpu.irqReq) && !s_q.isTrap)
            |-> s_q.cpu.irqVec == `PIE_VEC_BASE + {10'h000, pastWin, 2'h0};
    endproperty
    a_vec: assert property (p_vec) else $error("wrong vector");

    property p_pri;
        (s_q.st == PIE_WAIT && s_q.cnt == 3'h0 && !s_q.isTrap && !goXfer
            && cur.prio <= cpuLevel) |=> !s_q.cpu.irqReq;
    endproperty
    a_pri: assert property (p_pri) else $error("low priority taken");

    property p_clr;
        (s_q.st == PIE_REQ && cpuAck && !s_q.isTrap && !srcEvt[s_q.win])
            |=> !s_q.src[$past(pastWin)].req;
    endproperty
    a_clr: assert property (p_clr) else $error("flag not cleared");

    property p_rise;
        (s_q.edgeCfg[1:0] == `PIE_ES_RISE && fastLvl[0] && !s_q.prevIn[0])
            |=> s_q.src[0].req;
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed");

    property p_off;
        (s_q.edgeCfg[1:0] == `PIE_ES_OFF && s_q.edgeCfg[3:2] == `PIE_ES_OFF)
            |-> !fastEvt[0] && !fastEvt[1] && !wakeV[0] && pdOk[0];
    endproperty
    a_off: assert property (p_off) else $error("disabled input acts");

    property p_fall_pd;
        (s_q.edgeCfg[1:0] == `PIE_ES_FALL && !fastLvl[0]) |=> !s_q.pdAllow;
    endproperty
    a_fall_pd: assert property (p_fall_pd) else $error("sleep allowed while low");

    property p_and;
        (s_q.srcSel[1:0] == `PIE_SS_AND) |-> fastLvl[0] == (fastPin[0] & canRx0);
    endproperty
    a_and: assert property (p_and) else $error("source select wrong");

    c_xfer: cover property (s_q.xo.stb && s_q.xo.left == 8'h00);
    c_trap: cover property (s_q.cpu.irqReq && s_q.isTrap);
    c_wake: cover property (s_q.pdWake);
    c_irq: cover property (s_q.irqOut);

endmodule

// *** pie_map.svh ***
// Constants of the prioritised interrupt and event transfer block.
// Included by its bare name wherever the macros are needed; definitions only.
`ifndef PIE_MAP_SVH
`define PIE_MAP_SVH
// Sizes
`define PIE_NSRC 16
`define PIE_NCH 8
`define PIE_NFAST 8
`define PIE_SRC_W 10
`define PIE_CHC_W 11
// Register indices, byte address is four times the index
`define PIE_IDX_EDGE_CFG 16'hf1c0
`define PIE_IDX_SRC_SEL 16'hf1da
`define PIE_IDX_SRC_CTL 16'hf100
`define PIE_IDX_CH_CTL 16'hf110
`define PIE_IDX_CH_SRC 16'hf118
`define PIE_IDX_CH_DST 16'hf120
`define PIE_IDX_IRQ_STAT 16'hf128
`define PIE_IDX_IRQ_MASK 16'hf129
`define PIE_IDX_M16 16'hfff0
`define PIE_IDX_M8 16'hfff8
// Reset values
`define PIE_RST_EDGE_CFG 16'h0000
`define PIE_RST_SRC_SEL 16'h0000
// Edge and source select codes
`define PIE_ES_OFF 2'h0
`define PIE_ES_RISE 2'h1
`define PIE_ES_FALL 2'h2
`define PIE_ES_ANY 2'h3
`define PIE_SS_PIN 2'h0
`define PIE_SS_ALT 2'h1
`define PIE_SS_OR 2'h2
`define PIE_SS_AND 2'h3
// Vectors and pointer steps
`define PIE_VEC_BASE 16'h0040
`define PIE_STEP_BYTE 16'h0001
`define PIE_STEP_WORD 16'h0002
// Timing at the system clock
`define PIE_CLK_NS 40
`define PIE_LAT_MIN_NS 125
`define PIE_LAT_MAX_NS 300
`define PIE_LAT_MIN_CYC ((`PIE_LAT_MIN_NS + `PIE_CLK_NS - 1) / `PIE_CLK_NS)
`define PIE_LAT_MAX_CYC (`PIE_LAT_MAX_NS / `PIE_CLK_NS)
`define PIE_WAIT_CYC (`PIE_LAT_MIN_CYC - 2)
`endif

// *** pie_pkg.sv ***
// Types of the prioritised interrupt and event transfer block.
// Assumes pie_map.svh is on the include path.
package pie_pkg;
`include "pie_map.svh"
typedef enum logic [1:0] {PIE_IDLE, PIE_WAIT, PIE_REQ} pie_state_type;
typedef enum logic [3:0] {
    PIE_K_NONE, PIE_K_EDGE, PIE_K_SEL, PIE_K_SRC, PIE_K_CHC,
    PIE_K_CHS, PIE_K_CHD, PIE_K_STAT, PIE_K_MASK
} pie_kind_type;
typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [17:0] paddr;
    logic [31:0] pwdata;
} pie_apb_req_type;
typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
} pie_apb_rsp_type;
// Source control word, bit 9 down to bit 0
typedef struct packed {
    logic req;
    logic [2:0] ch;
    logic xfer;
    logic en;
    logic [3:0] prio;
} pie_src_type;
// Channel control word, bit 10 down to bit 0
typedef struct packed {
    logic cont;
    logic incDst;
    logic word;
    logic [7:0] cnt;
} pie_chctl_type;
typedef struct packed {
    pie_chctl_type ctl;
    logic [15:0] srcPtr;
    logic [15:0] dstPtr;
} pie_chan_type;
typedef struct packed {
    logic irqReq;
    logic [3:0] irqLevel;
    logic [15:0] irqVec;
} pie_cpu_type;
typedef struct packed {
    logic stb;
    logic word;
    logic [15:0] src;
    logic [15:0] dst;
    logic [7:0] left;
} pie_xfer_type;
typedef struct packed {
    pie_kind_type kind;
    logic [3:0] sub;
} pie_dec_type;
typedef struct packed {
    logic found;
    logic [3:0] idx;
} pie_win_type;
typedef struct packed {
    pie_state_type st;
    logic [2:0] cnt;
    logic [3:0] win;
    logic isTrap;
    logic trapPend;
    logic [3:0] trapNum;
    pie_src_type [`PIE_NSRC-1:0] src;
    pie_chan_type [`PIE_NCH-1:0] ch;
    logic [15:0] edgeCfg;
    logic [15:0] srcSel;
    logic [7:0] prevIn;
    logic [7:0] pdLvl;
    logic [7:0] stat;
    logic [7:0] mask;
    pie_apb_rsp_type rsp;
    pie_cpu_type cpu;
    pie_xfer_type xo;
    logic pdAllow;
    logic pdWake;
    logic irqOut;
} pie_reg_type;
endpackage

// *** tb_top.sv ***
// Self-checking bench for the interrupt and event transfer block.
// Assumes pie_pkg, pie_map.svh and pie_cpu_model; registers over APB.
`include "pie_map.svh"
module tb_top
    import pie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic slow = 1'b0;
    pie_apb_req_type apbReq = '0;
    pie_apb_rsp_type apbRsp;
    logic [7:0] fastPin = 8'h00;
    logic canRx0 = 1'b0;
    logic canRx1 = 1'b0;
    logic [7:0] perReq = 8'h00;
    logic [3:0] cpuLevel = 4'h0;
    logic trapValid = 1'b0;
    logic [3:0] trapNum = 4'h0;
    logic pdActive = 1'b0;
    logic cpuAck, pdAllow, pdWake, irqOut;
    pie_cpu_type cpuOut;
    pie_xfer_type xferOut;
    logic [31:0] rdData;
    logic rdErr;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int lat;

    pie_irq_ctrl u_pie_irq_ctrl (.clk_sys, .rstn, .ce, .apbReq, .apbRsp, .fastPin,
        .canRx0, .canRx1, .perReq, .cpuLevel, .cpuAck, .trapValid, .trapNum,
        .pdActive, .cpuOut, .xferOut, .pdAllow, .pdWake, .irqOut);
    pie_cpu_model u_pie_cpu_model (.clk_sys, .rstn, .cpuOut, .xferOut, .slow, .cpuAck);

    always #20 clk_sys = ~clk_sys;

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far above the several hundred cycles the tests need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
        int n;
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, wr, {idx, 2'b00}, {16'h0000, wd}};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk_sys);
            if (apbRsp.pready === 1'b1) break;
        end
        rdData = apbRsp.prdata;
        rdErr = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n == 16) check(1'b0, 1'b1);
    endtask

    task automatic w(input logic [15:0] idx, input logic [15:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic r(input logic [15:0] idx, input logic [15:0] e);
        apb(1'b0, idx, 16'h0000);
        check({rdErr, rdData}, {17'h0, e});
    endtask

    task automatic pulse(input logic [7:0] p);
        @(posedge clk_sys);
        perReq <= p;
        @(posedge clk_sys);
        perReq <= 8'h00;
    endtask

    task automatic popVec(input logic [19:0] e);
        check(u_pie_cpu_model.vecQ.size() ? u_pie_cpu_model.vecQ.pop_front() : 'x, e);
    endtask

    task automatic popXf(input logic [40:0] e);
        check(u_pie_cpu_model.xfQ.size() ? u_pie_cpu_model.xfQ.pop_front() : 'x, e);
    endtask

    initial begin
        tick(5);
        rstn <= 1'b1;
        // Register reset values, readback and an unmapped index
        r(`PIE_IDX_EDGE_CFG, `PIE_RST_EDGE_CFG);
        r(`PIE_IDX_SRC_SEL, `PIE_RST_SRC_SEL);
        w(`PIE_IDX_SRC_SEL, 16'ha5c3);
        r(`PIE_IDX_SRC_SEL, 16'ha5c3);
        w(`PIE_IDX_SRC_SEL, 16'h0000);
        w(16'h0000, 16'hffff);
        check(rdErr, 1'b1);
        apb(1'b0, 16'h0000, 16'h0000);
        check({rdErr, rdData}, {1'b1, 32'h0});
        for (int c = 0; c < 8; c++) begin
            w(`PIE_IDX_CH_SRC + 16'(c), 16'h1100 + 16'(c));
            r(`PIE_IDX_CH_SRC + 16'(c), 16'h1100 + 16'(c));
        end
        $display("test registers done");
        // Vectored service: latency, own vector, flag cleared when taken
        w(`PIE_IDX_SRC_CTL + 8, 16'h0015);
        pulse(8'h01);
        for (lat = 0; lat < 40 && cpuOut.irqReq !== 1'b1; lat++) tick(1);
        check(lat >= `PIE_LAT_MIN_CYC && lat <= `PIE_LAT_MAX_CYC, 1'b1);
        tick(4);
        popVec({4'h5, `PIE_VEC_BASE + 16'h0020});
        r(`PIE_IDX_SRC_CTL + 8, 16'h0015);
        // Highest level first, slow CPU; then only a higher level preempts
        slow <= 1'b1;
        w(`PIE_IDX_SRC_CTL + 9, 16'h0013);
        w(`PIE_IDX_SRC_CTL + 10, 16'h0017);
        pulse(8'h06);
        tick(24);
        popVec({4'h7, `PIE_VEC_BASE + 16'h0028});
        popVec({4'h3, `PIE_VEC_BASE + 16'h0024});
        slow <= 1'b0;
        cpuLevel <= 4'h7;
        pulse(8'h04);
        tick(12);
        check(u_pie_cpu_model.vecQ.size(), 0);
        cpuLevel <= 4'h6;
        tick(12);
        popVec({4'h7, `PIE_VEC_BASE + 16'h0028});
        cpuLevel <= 4'h0;
        // CPU rises to the pending level while the offer is still padded
        pulse(8'h04);
        tick(2);
        cpuLevel <= 4'h7;
        tick(12);
        check(u_pie_cpu_model.vecQ.size(), 0);
        cpuLevel <= 4'h0;
        tick(12);
        popVec({4'h7, `PIE_VEC_BASE + 16'h0028});
        $display("test vectored done");
        // Word transfers with destination step, count to zero, then vector
        w(`PIE_IDX_CH_CTL + 2, 16'h0302);
        w(`PIE_IDX_CH_SRC + 2, 16'h1000);
        w(`PIE_IDX_CH_DST + 2, 16'h2000);
        w(`PIE_IDX_IRQ_MASK, 16'h0004);
        w(`PIE_IDX_SRC_CTL + 11, 16'h00b4);
        for (int k = 0; k < 2; k++) begin
            pulse(8'h08);
            tick(10);
            popXf({1'b1, 16'h1000, 16'h2000 + 16'(2 * k), 8'(1 - k)});
        end
        check({u_pie_cpu_model.vecQ.size() != 0, irqOut}, 2'b01);
        r(`PIE_IDX_IRQ_STAT, 16'h0004);
        w(`PIE_IDX_IRQ_STAT, 16'h0004);
        tick(2);
        check(irqOut, 1'b0);
        pulse(8'h08);
        tick(10);
        popVec({4'h4, `PIE_VEC_BASE + 16'h002c});
        check(u_pie_cpu_model.xfQ.size(), 0);
        // Continuous byte transfers stepping the source, count left at zero
        w(`PIE_IDX_CH_CTL + 3, 16'h0400);
        w(`PIE_IDX_CH_SRC + 3, 16'h3000);
        w(`PIE_IDX_CH_DST + 3, 16'h4000);
        w(`PIE_IDX_SRC_CTL + 12, 16'h00f4);
        for (int k = 0; k < 2; k++) begin
            pulse(8'h10);
            tick(10);
            popXf({1'b0, 16'h3000 + 16'(k), 16'h4000, 8'h00});
        end
        $display("test transfer done");
        // Source select codes on inputs 0 to 2, pins low, both CAN lines toggled
        w(`PIE_IDX_SRC_CTL, 16'h0012);
        w(`PIE_IDX_SRC_CTL + 1, 16'h0012);
        w(`PIE_IDX_SRC_CTL + 2, 16'h0012);
        w(`PIE_IDX_EDGE_CFG, 16'h0015);
        for (int s = 0; s < 4; s++) begin
            w(`PIE_IDX_SRC_SEL, 16'(21 * s));
            canRx0 <= 1'b1;
            canRx1 <= 1'b1;
            tick(10);
            canRx0 <= 1'b0;
            canRx1 <= 1'b0;
            tick(10);
            check(u_pie_cpu_model.vecQ.size(), (s == 1 || s == 2) ? 2 : 0);
            u_pie_cpu_model.vecQ.delete();
        end
        w(`PIE_IDX_SRC_SEL, 16'h0000);
        // Edge codes: requests per pulse and power-down permission per level
        for (int e = 0; e < 4; e++) begin
            w(`PIE_IDX_EDGE_CFG, 16'(e));
            fastPin <= 8'h01;
            tick(10);
            check(pdAllow, e != 1);
            fastPin <= 8'h00;
            tick(10);
            check(pdAllow, e != 2);
            check(u_pie_cpu_model.vecQ.size(), e == 3 ? 2 : e != 0);
            u_pie_cpu_model.vecQ.delete();
        end
        w(`PIE_IDX_EDGE_CFG, 16'h0001);
        pdActive <= 1'b1;
        tick(3);
        check(pdWake, 1'b0);
        fastPin <= 8'h01;
        tick(3);
        check(pdWake, 1'b1);
        pdActive <= 1'b0;
        fastPin <= 8'h00;
        tick(10);
        u_pie_cpu_model.vecQ.delete();
        $display("test fast inputs done");
        // Software trap reported at the current level
        cpuLevel <= 4'h2;
        trapNum <= 4'h5;
        trapValid <= 1'b1;
        tick(1);
        trapValid <= 1'b0;
        tick(10);
        popVec({4'h2, `PIE_VEC_BASE + 16'h0014});
        $display("test trap done");
        stop_test();
    end
endmodule
